/* File: ctwc_consts.vh */
/*
 * Register offsets, field positions, reset values and widths for the
 * transmit wait / cancel flag block.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
 */
`ifndef CTWC_CONSTS_VH
`define CTWC_CONSTS_VH

`define CTWC_ADDR_W        6
`define CTWC_OFF_WAIT_UP   6'h00
`define CTWC_OFF_WAIT_LO   6'h04
`define CTWC_OFF_CAN_UP    6'h08
`define CTWC_OFF_CAN_LO    6'h0c
`define CTWC_OFF_ABORT_ACK_FLAGS     6'h10
`define CTWC_OFF_IRQ_STAT  6'h14
`define CTWC_OFF_IRQ_MASK  6'h18
`define CTWC_OFF_TX_CFG    6'h1c

`define CTWC_NMB           32
`define CTWC_RST_FLAGS     32'h00000000
`define CTWC_RST_MASK      2'h0
`define CTWC_LOW_VALID     32'hfffffffe
`define CTWC_IRQ_DONE_BIT  0
`define CTWC_IRQ_ABORT_BIT 1
`define CTWC_IRQ_W         2

`endif

/* File: ctwc_mbx_flags.v */
/*
 * Per-mailbox wait, cancel and abort-acknowledge flags for one mailbox.
 * Assumes single-cycle event pulses from the protocol engine on sys_clk.
 */
module ctwc_mbx_flags (
    sys_clk,
    resetn,
    set_wait,
    set_cancel,
    clr_ack,
    tx_active,
    tx_done,
    wait_bit,
    cancel_bit,
    ack_bit,
    abort_evt
);
    input  wire sys_clk;
    input  wire resetn;
    input  wire set_wait;
    input  wire set_cancel;
    input  wire clr_ack;
    input  wire tx_active;
    input  wire tx_done;
    output reg  wait_bit;
    output reg  cancel_bit;
    output reg  ack_bit;
    output wire abort_evt;

    // Abort only while pending, not on the bus, and not completing now
    assign abort_evt = wait_bit & cancel_bit & ~tx_active & ~tx_done;

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wait_bit   <= 1'b0;
            cancel_bit <= 1'b0;
            ack_bit    <= 1'b0;
        end else begin
            if (tx_done | abort_evt)
                wait_bit <= 1'b0;
            else if (set_wait)
                wait_bit <= 1'b1;
            if (tx_done | abort_evt)
                cancel_bit <= 1'b0;
            else if (set_cancel)
                cancel_bit <= 1'b1;
            if (abort_evt)
                ack_bit <= 1'b1;
            else if (clr_ack)
                ack_bit <= 1'b0;
        end
    end
endmodule

/* File: ctwc_top.v */
/*
 * Transmit wait and transmit cancel flag logic for 32 CAN mailboxes,
 * with an Avalon-MM register slave and one level interrupt.
 * Assumes the protocol engine gives tx_active levels and tx_done pulses on sys_clk.
 */
// Functional notes
// - Setting a wait bit queues that mailbox for bus arbitration.
// - Upper wait register bits 15..0 map to mailboxes 31..16.
// - Lower wait register bits 15..1 map to mailboxes 15..1.
// - Wait bit 0 means idle, 1 means pending transmission.
// - Wait bit clears on transmission completion or on abort completion.
// - Software writes never clear wait bits.
// - Writing 1 to wait or cancel works only for transmit mailboxes.
// - Lower wait bit 0 reserved, reads 0, software writes 0.
// - Cancel bit for mailboxes 16..31 attempts to withdraw pending message.
// - Cancel bit clears after successful cancel or after normal transmission end.
// - Successful cancel clears wait and cancel bits, sets abort acknowledge.
// - Cancel has no effect once the mailbox is transmitting.
// - Lower cancel bits 15..1 map mailboxes 15..1; bit 0 reserved zero.
`include "ctwc_consts.vh"
module ctwc_top (
    sys_clk,
    resetn,
    avs_address,
    avs_read,
    avs_write,
    avs_writedata,
    avs_byteenable,
    avs_readdata,
    avs_waitrequest,
    avs_response,
    tx_active,
    tx_done,
    transmit_wait_flags,
    transmit_cancel_flags,
    abort_ack_flags,
    irq
);
    input  wire                       sys_clk;
    input  wire                       resetn;
    input  wire [`CTWC_ADDR_W-1:0]    avs_address;
    input  wire                       avs_read;
    input  wire                       avs_write;
    input  wire [31:0]                avs_writedata;
    input  wire [3:0]                 avs_byteenable;
    output reg  [31:0]                avs_readdata;
    output wire                       avs_waitrequest;
    output reg  [1:0]                 avs_response;
    input  wire [`CTWC_NMB-1:0]       tx_active;
    input  wire [`CTWC_NMB-1:0]       tx_done;
    output wire [`CTWC_NMB-1:0]       transmit_wait_flags;
    output wire [`CTWC_NMB-1:0]       transmit_cancel_flags;
    output wire [`CTWC_NMB-1:0]       abort_ack_flags;
    output wire                       irq;

    localparam ST_IDLE = 2'b01;
    localparam ST_ACK  = 2'b10;

    reg  [1:0]              state_r;
    reg  [1:0]              state_nxt;
    reg  [`CTWC_NMB-1:0]    tx_cfg_r;
    reg  [`CTWC_IRQ_W-1:0]  irq_stat_r;
    reg  [`CTWC_IRQ_W-1:0]  irq_mask_r;
    reg  [31:0]             rdata_nxt;
    reg  [1:0]              resp_nxt;
    reg  [`CTWC_NMB-1:0]    set_wait;
    reg  [`CTWC_NMB-1:0]    set_cancel;
    reg  [`CTWC_NMB-1:0]    clr_ack;
    wire [`CTWC_NMB-1:0]    abort_evt;
    wire [31:0]             be_mask;
    wire [31:0]             wmask;
    wire                    wr_take;
    wire                    rd_take;
    wire                    any_done;
    wire                    any_abort;

    // Each access waits one cycle; answer taken in ST_ACK
    assign avs_waitrequest = (avs_read | avs_write) & state_r[0];
    assign wr_take = avs_write & state_r[1];
    assign rd_take = avs_read & state_r[0];
    assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wmask   = avs_writedata & be_mask;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (avs_read | avs_write) state_nxt = ST_ACK;
            ST_ACK:  state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Write decode: ones set wait/cancel of transmit mailboxes only; ones clear abort acks
    always @* begin
        set_wait   = {`CTWC_NMB{1'b0}};
        set_cancel = {`CTWC_NMB{1'b0}};
        clr_ack    = {`CTWC_NMB{1'b0}};
        if (wr_take) begin
            if (avs_address == `CTWC_OFF_WAIT_UP)
                set_wait = {wmask[15:0], 16'h0000} & tx_cfg_r;
            else if (avs_address == `CTWC_OFF_WAIT_LO)
                set_wait = {16'h0000, wmask[15:0]} & tx_cfg_r & `CTWC_LOW_VALID;
            else if (avs_address == `CTWC_OFF_CAN_UP)
                set_cancel = {wmask[15:0], 16'h0000} & tx_cfg_r;
            else if (avs_address == `CTWC_OFF_CAN_LO)
                set_cancel = {16'h0000, wmask[15:0]} & tx_cfg_r & `CTWC_LOW_VALID;
            else if (avs_address == `CTWC_OFF_ABORT_ACK_FLAGS)
                clr_ack = wmask & `CTWC_LOW_VALID;
        end
    end

    always @* begin
        rdata_nxt = 32'h00000000;
        resp_nxt  = 2'h0;
        if (avs_address == `CTWC_OFF_WAIT_UP)
            rdata_nxt = {16'h0000, transmit_wait_flags[31:16]};
        else if (avs_address == `CTWC_OFF_WAIT_LO)
            rdata_nxt = {16'h0000, transmit_wait_flags[15:1], 1'b0};
        else if (avs_address == `CTWC_OFF_CAN_UP)
            rdata_nxt = {16'h0000, transmit_cancel_flags[31:16]};
        else if (avs_address == `CTWC_OFF_CAN_LO)
            rdata_nxt = {16'h0000, transmit_cancel_flags[15:1], 1'b0};
        else if (avs_address == `CTWC_OFF_ABORT_ACK_FLAGS)
            rdata_nxt = {abort_ack_flags[31:1], 1'b0};
        else if (avs_address == `CTWC_OFF_IRQ_STAT)
            rdata_nxt = {30'h0, irq_stat_r};
        else if (avs_address == `CTWC_OFF_IRQ_MASK)
            rdata_nxt = {30'h0, irq_mask_r};
        else if (avs_address == `CTWC_OFF_TX_CFG)
            rdata_nxt = tx_cfg_r;
        else
            resp_nxt = 2'h2;
    end

    genvar g;
    generate
        for (g = 0; g < `CTWC_NMB; g = g + 1) begin : mbx
            ctwc_mbx_flags u_flags (
                .sys_clk    (sys_clk),
                .resetn     (resetn),
                .set_wait   (set_wait[g]),
                .set_cancel (set_cancel[g]),
                .clr_ack    (clr_ack[g]),
                .tx_active  (tx_active[g]),
                .tx_done    (tx_done[g]),
                .wait_bit   (transmit_wait_flags[g]),
                .cancel_bit (transmit_cancel_flags[g]),
                .ack_bit    (abort_ack_flags[g]),
                .abort_evt  (abort_evt[g])
            );
        end
    endgenerate

    assign any_done  = |(tx_done & transmit_wait_flags);
    assign any_abort = |abort_evt;
    assign irq       = |(irq_stat_r & irq_mask_r);

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r      <= ST_IDLE;
            tx_cfg_r     <= `CTWC_RST_FLAGS;
            irq_stat_r   <= {`CTWC_IRQ_W{1'b0}};
            irq_mask_r   <= `CTWC_RST_MASK;
            avs_readdata <= 32'h00000000;
            avs_response <= 2'h0;
        end else begin
            state_r <= state_nxt;
            if (rd_take) begin
                avs_readdata <= rdata_nxt;
                avs_response <= resp_nxt;
            end else if (avs_write & state_r[0]) begin
                avs_response <= resp_nxt;
            end
            if (wr_take && avs_address == `CTWC_OFF_TX_CFG)
                tx_cfg_r <= (tx_cfg_r & ~be_mask) | (wmask & `CTWC_LOW_VALID);
            if (wr_take && avs_address == `CTWC_OFF_IRQ_MASK)
                irq_mask_r <= wmask[`CTWC_IRQ_W-1:0];
            // Set wins over write-one-to-clear
            irq_stat_r[`CTWC_IRQ_DONE_BIT] <= any_done |
                (irq_stat_r[`CTWC_IRQ_DONE_BIT] &
                 ~(wr_take && avs_address == `CTWC_OFF_IRQ_STAT && wmask[`CTWC_IRQ_DONE_BIT]));
            irq_stat_r[`CTWC_IRQ_ABORT_BIT] <= any_abort |
                (irq_stat_r[`CTWC_IRQ_ABORT_BIT] &
                 ~(wr_take && avs_address == `CTWC_OFF_IRQ_STAT && wmask[`CTWC_IRQ_ABORT_BIT]));
        end
    end
endmodule

/* File: ctwc_properties.sv */
/* Port checker for ctwc_top.
   Assumes it is bound to ctwc_top: one clock, async active-low reset. */
module ctwc_properties (
    input wire        sys_clk,
    input wire        resetn,
    input wire        avs_read,
    input wire        avs_write,
    input wire        avs_waitrequest,
    input wire [31:0] tx_active,
    input wire [31:0] tx_done,
    input wire [31:0] transmit_wait_flags,
    input wire [31:0] transmit_cancel_flags,
    input wire [31:0] abort_ack_flags
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [31:0] wt = transmit_wait_flags;
    wire [31:0] cn = transmit_cancel_flags;
    wire [31:0] af = abort_ack_flags;
    wire [31:0] abt = wt & cn & ~tx_active & ~tx_done;
    wire [31:0] hld = wt & cn & tx_active & ~tx_done;
    wire [31:0] tie = cn & tx_done;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_req_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_req_done;
        (avs_read || avs_write) && !avs_waitrequest;
    endsequence
    a_bus_answer: assert property ($rose(avs_read || avs_write) |-> s_req_wait ##1 s_req_done)
        else $error("bus request not answered");
    a_resv_zero: assert property (!wt[0] && !cn[0])
        else $error("reserved bit set");
    a_done_clear: assert property (|(tx_done & wt) |=> ((wt | cn) & $past(tx_done)) == 0)
        else $error("completion left flags set");
    a_abort_ack: assert property (|abt |=> (af & $past(abt)) == $past(abt) && ((wt | cn) & $past(abt)) == 0)
        else $error("abort not acknowledged");
    a_active_keep: assert property (|hld |=> (wt & $past(hld)) == $past(hld))
        else $error("active transmission withdrawn");
    a_tie_no_ack: assert property (|tie |=> (af & $past(tie)) == ($past(af) & $past(tie)))
        else $error("ack set on completion");
    a_wait_sticky: assert property (($past(wt) & ~wt & ~$past(tx_done) & ~$past(abt)) == 0)
        else $error("wait bit dropped without event");
    a_cancel_hold: assert property (($past(cn) & ~cn & wt) == 0)
        else $error("cancel dropped while pending");
endmodule
bind ctwc_top ctwc_properties ctwc_properties_inst (
    .sys_clk(sys_clk), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .tx_active(tx_active), .tx_done(tx_done),
    .transmit_wait_flags(transmit_wait_flags), .transmit_cancel_flags(transmit_cancel_flags),
    .abort_ack_flags(abort_ack_flags));

/* File: ctwc_engine_model.sv */
/* Protocol engine model: sends one pending mailbox on command.
   Assumes the bench pulses go with mailbox and frame length. */
module ctwc_engine_model (
    input wire         sys_clk,
    input wire         resetn,
    input wire         go,
    input wire [4:0]   mb,
    input wire [7:0]   len,
    input wire [31:0]  transmit_wait_flags,
    output logic [31:0] tx_active,
    output logic [31:0] tx_done,
    output logic        busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_r;
    logic [4:0] cur_r;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tx_active <= '0;
            tx_done <= '0;
            busy <= 1'b0;
            cnt_r <= '0;
            cur_r <= '0;
        end else begin
            tx_done <= '0;
            if (go && !busy && transmit_wait_flags[mb]) begin
                busy <= 1'b1;
                cur_r <= mb;
                cnt_r <= len;
                tx_active[mb] <= 1'b1;
            end else if (busy && cnt_r == 0) begin
                busy <= 1'b0;
                tx_active[cur_r] <= 1'b0;
                tx_done[cur_r] <= 1'b1;
            end else if (busy) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
endmodule

/* File: ctwc_top_tb_top.sv */
/* Self-checking bench for ctwc_top with the engine model.
   Assumes the register map of ctwc_consts.vh. */
`include "ctwc_consts.vh"
module ctwc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 0, resetn = 0, rd = 0, wr = 0, go = 0, wreq, irq, busy;
    logic [5:0]  adr = 0;
    logic [4:0]  mb = 0;
    logic [7:0]  len = 0;
    logic [1:0]  resp;
    logic [31:0] wdat = 0, rdat, act, done, wf, cf, af, cfg, seed = 32'h92ce;
    logic [33:0] expq[$];
    int          n_fail = 0, checks = 0, cyc = 0;
    ctwc_top ctwc_top_inst (.sys_clk(sys_clk), .resetn(resetn), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .avs_response(resp), .tx_active(act), .tx_done(done),
        .transmit_wait_flags(wf), .transmit_cancel_flags(cf), .abort_ack_flags(af), .irq(irq));
    ctwc_engine_model ctwc_engine_model_inst (.sys_clk(sys_clk), .resetn(resetn), .go(go), .mb(mb),
        .len(len), .transmit_wait_flags(wf), .tx_active(act), .tx_done(done), .busy(busy));
    initial forever #50 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        @(posedge sys_clk);
        while (wreq) @(posedge sys_clk);
        rd <= 0;
        wr <= 0;
    endtask
    task automatic rdx(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
        expq.push_back({r, d});
        bus(0, a, 0);
    endtask
    task automatic txm(input logic [4:0] m, input logic [7:0] l);
        @(posedge sys_clk);
        go <= 1;
        mb <= m;
        len <= l;
        @(posedge sys_clk);
        go <= 0;
        do @(posedge sys_clk); while (busy);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) if (rd && !wreq) chk("read", {resp, rdat}, expq.pop_front());
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            end_sim;
        end
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1;
        for (int i = 0; i < 8; i++) rdx(6'(i * 4), 0, 0);
        rdx(6'h20, 0, 2);
        $display("test reset done");
        seed = xs(seed);
        cfg = (seed | 32'h00300006) & 32'h7ffffffe;
        bus(1, `CTWC_OFF_TX_CFG, cfg);
        bus(1, `CTWC_OFF_WAIT_UP, cfg[31:16]);
        bus(1, `CTWC_OFF_WAIT_LO, cfg[15:0]);
        bus(1, `CTWC_OFF_WAIT_LO, 0);
        rdx(`CTWC_OFF_WAIT_UP, cfg[31:16], 0);
        rdx(`CTWC_OFF_WAIT_LO, cfg[15:0], 0);
        chk("wait", wf, cfg);
        $display("test set done");
        bus(1, `CTWC_OFF_IRQ_MASK, 2);
        txm(20, 4);
        rdx(`CTWC_OFF_IRQ_STAT, 1, 0);
        chk("irq masked", irq, 0);
        bus(1, `CTWC_OFF_IRQ_MASK, 3);
        @(negedge sys_clk);
        chk("irq", irq, 1);
        bus(1, `CTWC_OFF_IRQ_STAT, 1);
        rdx(`CTWC_OFF_WAIT_UP, cfg[31:16] & 16'hffef, 0);
        chk("irq clear", irq, 0);
        bus(1, `CTWC_OFF_CAN_UP, 32'h20);
        rdx(`CTWC_OFF_ABORT_ACK_FLAGS, 32'h00200000, 0);
        chk("abort21", {wf[21], cf[21]}, 0);
        chk("irq abort", irq, 1);
        fork
            txm(1, 8);
            begin
                repeat (3) @(posedge sys_clk);
                bus(1, `CTWC_OFF_CAN_LO, 32'h2);
            end
        join
        rdx(`CTWC_OFF_ABORT_ACK_FLAGS, 32'h00200000, 0);
        chk("cancel1", {wf[1], cf[1], cf[0]}, 0);
        rdx(`CTWC_OFF_IRQ_STAT, 3, 0);
        bus(1, `CTWC_OFF_ABORT_ACK_FLAGS, 32'h00200000);
        bus(1, `CTWC_OFF_IRQ_STAT, 3);
        rdx(`CTWC_OFF_ABORT_ACK_FLAGS, 0, 0);
        rdx(`CTWC_OFF_IRQ_STAT, 0, 0);
        chk("irq end", irq, 0);
        $display("test cancel done");
        end_sim;
    end
endmodule
